// file: design/afr_pkg.sv
// Package: constants and carrier types for the asynchronous FIFO controller
package afr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned AFR_DEPTH      = 512;
  localparam int unsigned AFR_WIDTH      = 9;
  localparam int unsigned AFR_HALF       = AFR_DEPTH / 2;
  localparam int unsigned AFR_CNT_W      = 10;

  // ****************************************************************
  // Timing (ns) and derived cycle counts at 50 MHz
  // ****************************************************************
  localparam int unsigned AFR_CLK_NS     = 20;
  localparam int unsigned AFR_PULSE_NS   = 20;
  localparam int unsigned AFR_RECOV_NS   = 10;
  localparam int unsigned AFR_SETUP_NS   = 12;
  localparam int unsigned AFR_PULSE_CYC  = (AFR_PULSE_NS + AFR_CLK_NS - 1) / AFR_CLK_NS;
  localparam int unsigned AFR_RECOV_CYC  = (AFR_RECOV_NS + AFR_CLK_NS - 1) / AFR_CLK_NS;
  localparam int unsigned AFR_SETUP_CYC  = (AFR_SETUP_NS + AFR_CLK_NS - 1) / AFR_CLK_NS;
  localparam logic [3:0]  AFR_PULSE_LEN  = 4'(AFR_PULSE_CYC);
  localparam logic [3:0]  AFR_RECOV_LEN  = 4'(AFR_RECOV_CYC);
  localparam logic [3:0]  AFR_SETUP_LEN  = 4'(AFR_SETUP_CYC);

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [AFR_CNT_W-1:0] AFR_CNT_RST  = 10'h000;
  localparam logic [AFR_WIDTH-1:0] AFR_DATA_RST = 9'h000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {AFR_OP_NONE, AFR_OP_CLEAR, AFR_OP_PUSH, AFR_OP_POP,
                            AFR_OP_REPLAY} afr_op_e;

  typedef enum {AFR_IDLE, AFR_SETUP, AFR_LOW, AFR_HIGH, AFR_RECOV} afr_state_e;

  typedef struct packed
  {
    logic                 push_n;
    logic                 pop_n;
    logic                 clear;
    logic                 replay_n;
    logic [AFR_WIDTH-1:0] wdata;
  } afr_pins_s;

  typedef struct packed
  {
    logic                 empty_n;
    logic                 full_n;
    logic                 half_n;
    logic [AFR_WIDTH-1:0] rdata;
    logic                 rdata_oe;
  } afr_flags_s;

endpackage : afr_pkg

// file: design/afr_sync.sv
// Two-stage synchroniser for the device's flag and data outputs
`timescale 1ns/1ps
module afr_sync
  import afr_pkg::*;
#(
  parameter int unsigned W = 12
)
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } afr_sync_s;

  afr_sync_s st;
  afr_sync_s next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.s2;

endmodule : afr_sync

// file: design/afr_ctrl.sv
// Controller that drives the asynchronous FIFO's strobes and tracks its flags
//
// Function
// - Strobes held high around master_clear release
// - Push rising edge writes; data held
// - Strobes high during replay and recovery
// - Replay only after at most depth writes
// - Standalone: chain_in low, first_load high
// - Depth cascade ring set during clear
// - Cascade: OR flags, no half/replay
// - Use flags to avoid empty/full access
`timescale 1ns/1ps
module afr_ctrl
  import afr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // User side
  input  wire logic                 cmd_valid,
  input  wire afr_op_e              cmd_op,
  input  wire logic [AFR_WIDTH-1:0] cmd_wdata,
  output logic                      cmd_ready,
  output logic                      cmd_done,
  output logic                      cmd_refused,
  output logic [AFR_WIDTH-1:0]      rd_data,
  output logic                      rd_valid,
  output logic                      fifo_empty,
  output logic                      fifo_full,
  output logic                      fifo_half,
  output logic [AFR_CNT_W-1:0]      writes_since_clear,
  // Device side
  output logic                      input_push_n,
  output logic                      output_pop_n,
  output logic                      master_clear,
  output logic                      replay_input,
  output logic [AFR_WIDTH-1:0]      write_data,
  output logic                      chain_in,
  output logic                      first_load_select,
  input  wire logic                 empty_flag,
  input  wire logic                 full_flag,
  input  wire logic                 half_full,
  input  wire logic [AFR_WIDTH-1:0] read_data,
  input  wire logic                 read_data_oe
);

  localparam int unsigned SW = 3 + AFR_WIDTH + 1;

  // ****************************************************************
  // Synchronised device outputs
  // ****************************************************************
  logic [SW-1:0] sync_out;
  afr_flags_s    dev;

  afr_sync #(
    .W (SW)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      ({empty_flag, full_flag, half_full, read_data, read_data_oe}),
    .dout     (sync_out)
  );

  assign dev = afr_flags_s'(sync_out);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    afr_state_e           fsm;
    afr_op_e              op;
    logic [3:0]           cnt;
    afr_pins_s            pins;
    logic                 done;
    logic                 refused;
    logic [AFR_WIDTH-1:0] rdata;
    logic                 rvalid;
    logic [AFR_CNT_W-1:0] writes;
    logic                 cleared;
  } afr_ctrl_s;

  afr_ctrl_s st;
  afr_ctrl_s next_st;

  always_comb
  begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.refused = 1'b0;
    next_st.rvalid  = 1'b0;
    case (st.fsm)
      AFR_IDLE:
      begin
        if (cmd_valid)
        begin
          next_st.op  = cmd_op;
          next_st.cnt = 4'h0;
          case (cmd_op)
            AFR_OP_CLEAR:
            begin
              next_st.fsm = AFR_SETUP;
            end
            AFR_OP_PUSH:
            begin
              if (!st.cleared || !dev.full_n)
              begin
                next_st.refused = 1'b1;
              end
              else
              begin
                next_st.pins.wdata = cmd_wdata;
                next_st.fsm        = AFR_SETUP;
              end
            end
            AFR_OP_POP:
            begin
              if (!st.cleared || !dev.empty_n)
              begin
                next_st.refused = 1'b1;
              end
              else
              begin
                next_st.fsm = AFR_SETUP;
              end
            end
            AFR_OP_REPLAY:
            begin
              if (!st.cleared || st.writes > 10'(AFR_DEPTH))
              begin
                next_st.refused = 1'b1;
              end
              else
              begin
                next_st.fsm = AFR_SETUP;
              end
            end
            default:
            begin
              next_st.refused = 1'b1;
            end
          endcase
        end
      end
      AFR_SETUP:
      begin
        // Data stable and other strobes high before asserting
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt + 4'h1 >= AFR_SETUP_LEN)
        begin
          next_st.cnt = 4'h0;
          next_st.fsm = AFR_LOW;
          case (st.op)
            AFR_OP_CLEAR:  next_st.pins.clear    = 1'b1;
            AFR_OP_PUSH:   next_st.pins.push_n   = 1'b0;
            AFR_OP_POP:    next_st.pins.pop_n    = 1'b0;
            AFR_OP_REPLAY: next_st.pins.replay_n = 1'b0;
            default:       next_st.fsm           = AFR_IDLE;
          endcase
        end
      end
      AFR_LOW:
      begin
        // Pop stays low until its data has crossed the synchroniser
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt + 4'h1 >= ((st.op == AFR_OP_POP) ? AFR_PULSE_LEN + 4'h2 : AFR_PULSE_LEN))
        begin
          next_st.cnt = 4'h0;
          next_st.fsm = AFR_HIGH;
          if (st.op == AFR_OP_POP)
          begin
            next_st.rdata  = dev.rdata;
            next_st.rvalid = dev.rdata_oe;
          end
          next_st.pins.push_n   = 1'b1;
          next_st.pins.pop_n    = 1'b1;
          next_st.pins.clear    = 1'b0;
          next_st.pins.replay_n = 1'b1;
        end
      end
      AFR_HIGH:
      begin
        next_st.fsm = AFR_RECOV;
        case (st.op)
          AFR_OP_CLEAR:
          begin
            next_st.writes  = AFR_CNT_RST;
            next_st.cleared = 1'b1;
          end
          AFR_OP_PUSH:
          begin
            if (st.writes != 10'h3FF)
            begin
              next_st.writes = st.writes + 10'h001;
            end
          end
          default:
          begin
          end
        endcase
      end
      AFR_RECOV:
      begin
        // Strobes stay high through recovery and flag settling
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt + 4'h1 >= AFR_RECOV_LEN + 4'h2)
        begin
          next_st.cnt  = 4'h0;
          next_st.fsm  = AFR_IDLE;
          next_st.done = 1'b1;
        end
      end
      default:
      begin
        next_st.fsm = AFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st               <= '0;
      st.fsm           <= AFR_IDLE;
      st.op            <= AFR_OP_NONE;
      st.pins.push_n   <= 1'b1;
      st.pins.pop_n    <= 1'b1;
      st.pins.replay_n <= 1'b1;
      st.pins.wdata    <= AFR_DATA_RST;
      st.rdata         <= AFR_DATA_RST;
      st.writes        <= AFR_CNT_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready          = (st.fsm == AFR_IDLE);
  assign cmd_done           = st.done;
  assign cmd_refused        = st.refused;
  assign rd_data            = st.rdata;
  assign rd_valid           = st.rvalid;
  assign fifo_empty         = !dev.empty_n;
  assign fifo_full          = !dev.full_n;
  assign fifo_half          = !dev.half_n;
  assign writes_since_clear = st.writes;
  assign input_push_n       = st.pins.push_n;
  assign output_pop_n       = st.pins.pop_n;
  assign master_clear       = st.pins.clear;
  assign replay_input       = st.pins.replay_n;
  assign write_data         = st.pins.wdata;
  // Standalone configuration straps
  assign chain_in           = 1'b0;
  assign first_load_select  = 1'b1;

endmodule : afr_ctrl

// file: testbench/afr_ctrl_monitor.sv
// Checker for the controller's device-side strobes
`timescale 1ns/1ps
module afr_ctrl_monitor
  import afr_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 cmd_done,
  input wire logic                 cmd_refused,
  input wire logic                 fifo_empty,
  input wire logic                 fifo_full,
  input wire logic [AFR_CNT_W-1:0] writes_since_clear,
  input wire logic                 input_push_n,
  input wire logic                 output_pop_n,
  input wire logic                 master_clear,
  input wire logic                 replay_input,
  input wire logic [AFR_WIDTH-1:0] write_data,
  input wire logic                 chain_in,
  input wire logic                 first_load_select
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic idle;
  assign idle = input_push_n && output_pop_n;
  sequence s_push_low;
    $fell(input_push_n);
  endsequence
  sequence s_push_end;
    $stable(write_data) ##1 (input_push_n && $stable(write_data));
  endsequence
  sequence s_pop_hold;
    !output_pop_n ##1 !output_pop_n ##1 output_pop_n;
  endsequence
  a_push_data_held: assert property (s_push_low |-> s_push_end)
    else $error("write strobe or data not held");
  a_pop_width: assert property ($fell(output_pop_n) |=> s_pop_hold)
    else $error("read strobe not three cycles");
  a_push_done_lat: assert property (s_push_low |-> ##5 cmd_done)
    else $error("push done not on time");
  a_write_count: assert property ($rose(input_push_n) && writes_since_clear != 10'h3FF
    |=> writes_since_clear == $past(writes_since_clear) + 10'h001)
    else $error("write count not advanced");
  a_pop_not_empty: assert property ($fell(output_pop_n) |-> !fifo_empty)
    else $error("read issued while empty");
  a_push_not_full: assert property (s_push_low |-> !fifo_full)
    else $error("write issued while full");
  a_clear_quiet: assert property (master_clear || $past(master_clear) |-> idle)
    else $error("strobe active around clear");
  a_clear_zero: assert property ($fell(master_clear) |-> ##[0:4] writes_since_clear == 10'h000)
    else $error("write count not cleared");
  a_replay_quiet: assert property (!replay_input || !$past(replay_input) |-> idle)
    else $error("strobe active around replay");
  a_refuse_idle: assert property (cmd_refused |-> idle && !master_clear && replay_input)
    else $error("pin activity on refusal");
  a_standalone_pins: assert property (!chain_in && first_load_select)
    else $error("mode pins not standalone");
endmodule : afr_ctrl_monitor

bind afr_ctrl afr_ctrl_monitor u_mon (.*);

// file: testbench/afr_dev_model.sv
// Behavioural model of the 512 x 9 asynchronous FIFO device
`timescale 1ns/1ps
module afr_dev_model
  import afr_pkg::*;
(
  input  wire logic                 input_push_n,
  input  wire logic                 output_pop_n,
  input  wire logic                 master_clear,
  input  wire logic                 replay_input,
  input  wire logic [AFR_WIDTH-1:0] write_data,
  output logic                      empty_flag,
  output logic                      full_flag,
  output logic                      half_full,
  output logic [AFR_WIDTH-1:0]      read_data,
  output logic                      read_data_oe
);
  // ****
  // Storage, pointers and flags
  // ****
  logic [AFR_WIDTH-1:0] mem [AFR_DEPTH];
  logic [8:0]           wp = '0;
  logic [8:0]           rp = '0;
  logic [AFR_WIDTH-1:0] q = '0;
  int                   cnt = 0;
  int                   nw = 0;
  int                   wr_ok = 0;
  int                   rd_ok = 0;
  assign empty_flag = (cnt - rd_ok) != 0;
  assign full_flag = (cnt + wr_ok) != AFR_DEPTH;
  assign half_full = (cnt + wr_ok) <= AFR_HALF;
  // Floating bus shows inverse of last word
  assign read_data = read_data_oe ? q : ~q;
  initial read_data_oe = 1'b0;
  always @(posedge master_clear)
  begin
    wp = '0;
    rp = '0;
    cnt = 0;
    nw = 0;
    wr_ok = 0;
    rd_ok = 0;
    read_data_oe = 1'b0;
  end
  always @(negedge input_push_n)
    wr_ok = (cnt != AFR_DEPTH) ? 1 : 0;
  always @(posedge input_push_n)
    if (wr_ok != 0)
    begin
      mem[wp] = write_data;
      wp++;
      cnt++;
      nw++;
      wr_ok = 0;
    end
  always @(negedge output_pop_n)
    if (cnt != 0)
    begin
      rd_ok = 1;
      q = mem[rp];
      read_data_oe = 1'b1;
    end
  always @(posedge output_pop_n)
    if (rd_ok != 0)
    begin
      rp++;
      cnt--;
      rd_ok = 0;
      read_data_oe = 1'b0;
    end
  always @(negedge replay_input)
  begin
    rp = '0;
    cnt = nw;
  end
endmodule : afr_dev_model

// file: testbench/afr_tb.sv
// Testbench for the FIFO controller against the device model
`timescale 1ns/1ps
module tb;
  import afr_pkg::*;
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  afr_op_e cmd_op = AFR_OP_NONE;
  logic [AFR_WIDTH-1:0] cmd_wdata = '0;
  logic cmd_ready, cmd_done, cmd_refused, rd_valid, fifo_empty, fifo_full, fifo_half, rdv;
  logic [AFR_WIDTH-1:0] rd_data, write_data, read_data, pin_word, rdw;
  logic [AFR_CNT_W-1:0] writes_since_clear;
  logic input_push_n, output_pop_n, master_clear, replay_input, chain_in, first_load_select;
  logic empty_flag, full_flag, half_full, read_data_oe;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  afr_ctrl u_dut (.*);
  afr_dev_model u_dev (.*);
  // ****
  // Clock, timeout, bus sampling
  // ****
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk)
    if (read_data_oe === 1'b1)
      pin_word = read_data;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic do_op(input afr_op_e op, input logic [AFR_WIDTH-1:0] w, input logic ref_e);
    int n;
    @(posedge core_clk);
    #1;
    `CHK("cmd_ready", 1'b1, cmd_ready)
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = w;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    `CHK("cmd_ready", ref_e, cmd_ready)
    rdv = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (rd_valid === 1'b1)
      begin
        rdv = 1'b1;
        rdw = rd_data;
      end
    end
    `CHK("refused", ref_e, cmd_refused)
    `CHK("done", !ref_e, cmd_done)
  endtask : do_op
  task automatic pop_chk(input logic [AFR_WIDTH-1:0] e);
    do_op(AFR_OP_POP, 9'h000, 1'b0);
    `CHK("pin_word", e, pin_word)
    `CHK("rd_valid", 1'b1, rdv)
    `CHK("rd_data", e, rdw)
  endtask : pop_chk
  task automatic flags(input logic e, input logic f, input logic h);
    `CHK("fifo_empty", e, fifo_empty)
    `CHK("fifo_full", f, fifo_full)
    `CHK("fifo_half", h, fifo_half)
  endtask : flags
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    do_op(AFR_OP_PUSH, 9'h001, 1'b1);
    do_op(AFR_OP_CLEAR, 9'h000, 1'b0);
    flags(1'b1, 1'b0, 1'b0);
    `CHK("oe", 1'b0, read_data_oe)
    do_op(AFR_OP_POP, 9'h000, 1'b1);
    do_op(AFR_OP_NONE, 9'h000, 1'b1);
    for (int i = 0; i < 3; i++)
      do_op(AFR_OP_PUSH, 9'h1A0 + 9'(i), 1'b0);
    flags(1'b0, 1'b0, 1'b0);
    `CHK("writes", 10'h003, writes_since_clear)
    for (int i = 0; i < 3; i++)
      pop_chk(9'h1A0 + 9'(i));
    flags(1'b1, 1'b0, 1'b0);
    `CHK("oe", 1'b0, read_data_oe)
    do_op(AFR_OP_POP, 9'h000, 1'b1);
    do_op(AFR_OP_REPLAY, 9'h000, 1'b0);
    do_op(AFR_OP_PUSH, 9'h0C3, 1'b0);
    for (int i = 0; i < 3; i++)
      pop_chk(9'h1A0 + 9'(i));
    pop_chk(9'h0C3);
    do_op(AFR_OP_CLEAR, 9'h000, 1'b0);
    `CHK("writes", 10'h000, writes_since_clear)
    for (int i = 0; i < 512; i++)
    begin
      do_op(AFR_OP_PUSH, 9'(i), 1'b0);
      if (i == 255 || i == 256)
        `CHK("fifo_half", i == 256, fifo_half)
    end
    flags(1'b0, 1'b1, 1'b1);
    do_op(AFR_OP_PUSH, 9'h0AA, 1'b1);
    pop_chk(9'h000);
    flags(1'b0, 1'b0, 1'b1);
    do_op(AFR_OP_PUSH, 9'h155, 1'b0);
    for (int i = 1; i < 512; i++)
    begin
      pop_chk(9'(i));
      if (i == 255 || i == 256)
        `CHK("fifo_half", i == 255, fifo_half)
    end
    pop_chk(9'h155);
    flags(1'b1, 1'b0, 1'b0);
    do_op(AFR_OP_REPLAY, 9'h000, 1'b1);
    stop_test();
  end
endmodule : tb
